// ---- verilog/readout_pkg.sv ----
// Purpose: Shared constants and types of the frame readout sequencer
// Assumes: 32-bit AXI4-Lite register bus, 12-bit row and column counters
// Notes:   Counts are in rows or pixel ticks, the request filter count in aclk cycles, not in time units
// ============================================================
// Package
package readout_pkg;
  // ==========================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_READ_MODE = 8'h04;
  localparam logic [7:0] ADDR_FRAME_LINES = 8'h08;
  localparam logic [7:0] ADDR_LINE_LEN = 8'h0C;
  localparam logic [7:0] ADDR_WINDOW = 8'h10;
  localparam logic [7:0] ADDR_INTEG = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // ==========================================================
  // Field positions
  localparam int CTRL_VIDEO_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam int CTRL_STREAM_BIT = 2;
  localparam int MIRROR_COL_BIT = 14;
  localparam int MIRROR_ROW_BIT = 15;
  localparam int WIN_ROWS_LSB = 0;
  localparam int WIN_COLS_LSB = 16;
  localparam int CNT_W = 12;
  // ==========================================================
  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [11:0] FRAME_LINES_RST = 12'h020;
  localparam logic [11:0] LINE_LEN_RST = 12'h010;
  localparam logic [11:0] ROWS_RST = 12'h008;
  localparam logic [11:0] COLS_RST = 12'h008;
  localparam logic [11:0] INTEG_RST = 12'h004;
  // ==========================================================
  // Timing counts
  localparam logic [1:0] TRIG_HIGH_CYCLES = 2'h3;
  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Sequencer states, Gray along wait-integ-active-blank
  typedef enum logic [1:0] {
    ST_WAIT = 2'h0,
    ST_INTEG = 2'h1,
    ST_ACTIVE = 2'h3,
    ST_BLANK = 2'h2
  } seq_state_t;
endpackage

// ---- verilog/frame_readout_sequencer.sv ----
// Purpose: Rolling-shutter readout sequencer with AXI4-Lite registers
// Assumes: pixel_output_clock and capture_request are asynchronous to aclk
// Notes:   One pixel is produced per sampled rising edge of the pixel clock, only within the window columns of active rows
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// R01: Column mirror reverses column order, keeping the starting Bayer color.
// R02: Host retriggers column correction and enables resampling when mirroring columns.
// R03: Row mirror reverses row order, one-pixel array shift keeps the Bayer color.
// R04: Timing-affecting write in video mode restarts shutter at next frame start.
// R05: Bubble length equals integration rows times the newly written row period.
// R06: Integration time writes take effect two frames after they were written.
// R07: Frame-synchronized fields apply on the frame following the write.
// R08: Single mode writes between frame end and trigger apply to the next frame.
// R09: Unsynchronized fields update as soon as the write completes.
// R10: Restart aborts the frame, applies pending writes, starts a new frame.
// R11: Restart waits for the row in progress to finish.
// R12: Each frame resets rows first, then samples and returns them to reset. Video frames without a bubble skip the reset pass (ST_BLANK to ST_ACTIVE).
// R13: Single mode keeps reading frames while the request is high, else waits.
// R14: Request sampled only while frame inactive, needs three consecutive high cycles.
// R15: Strobe output is high during integration in both modes.
// R16: Host holds request high, or until stream is set, for synchronized streaming.
// R17: Sensors on a shared request stay aligned within one or two pixel clocks.
// R18: Frame-active flag high from first to last output row, low in blanking.
module frame_readout_sequencer import readout_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sensor pins
  input wire logic pixel_output_clock,
  input wire logic capture_request,
  output logic frame_active_flag,
  output logic strobe_out,
  // Pixel stream
  output logic [11:0] pixel_data,
  output logic pixel_valid,
  input wire logic pixel_ready
);
  // ==========================================================
  // Register bus
  logic aw_held_reg, w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic [31:0] wmask;
  logic [1:0] ctrl_reg;
  logic mirror_col_reg, mirror_row_reg;
  logic [CNT_W-1:0] frame_lines_reg, line_len_reg, rows_reg, cols_reg, integ_reg;
  logic restart_pend_reg, bubble_pend_reg;
  logic [31:0] rd_word;
  logic rd_ok;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] old, input logic [CNT_W-1:0] nw,
                                             input logic [CNT_W-1:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg[7:2] <= ADDR_INTEG[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register storage; fields take their new value the cycle the write completes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
      mirror_col_reg <= 1'b0;
      mirror_row_reg <= 1'b0;
      frame_lines_reg <= FRAME_LINES_RST;
      line_len_reg <= LINE_LEN_RST;
      rows_reg <= ROWS_RST;
      cols_reg <= COLS_RST;
      integ_reg <= INTEG_RST;
    end else if (wr_fire) begin
      unique case (aw_addr_reg)
        ADDR_CTRL: begin
          if (wmask[CTRL_STREAM_BIT]) ctrl_reg[1] <= w_data_reg[CTRL_STREAM_BIT]; // [R09]
          if (wmask[CTRL_VIDEO_BIT]) ctrl_reg[0] <= w_data_reg[CTRL_VIDEO_BIT]; // [R09]
        end
        ADDR_READ_MODE: begin
          if (wmask[MIRROR_COL_BIT]) mirror_col_reg <= w_data_reg[MIRROR_COL_BIT];
          if (wmask[MIRROR_ROW_BIT]) mirror_row_reg <= w_data_reg[MIRROR_ROW_BIT];
        end
        ADDR_FRAME_LINES: frame_lines_reg <= merge(frame_lines_reg, w_data_reg[CNT_W-1:0], wmask[CNT_W-1:0]);
        ADDR_LINE_LEN: line_len_reg <= merge(line_len_reg, w_data_reg[CNT_W-1:0], wmask[CNT_W-1:0]);
        ADDR_WINDOW: begin
          rows_reg <= merge(rows_reg, w_data_reg[WIN_ROWS_LSB +: CNT_W], wmask[WIN_ROWS_LSB +: CNT_W]);
          cols_reg <= merge(cols_reg, w_data_reg[WIN_COLS_LSB +: CNT_W], wmask[WIN_COLS_LSB +: CNT_W]);
        end
        ADDR_INTEG: integ_reg <= merge(integ_reg, w_data_reg[CNT_W-1:0], wmask[CNT_W-1:0]);
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Input synchronisers
  logic pclk_s1, pclk_s2, pclk_s3;
  logic trig_s1, trig_s2;
  logic [1:0] trig_cnt_reg;
  logic trig_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pclk_s1 <= 1'b0;
      pclk_s2 <= 1'b0;
      pclk_s3 <= 1'b0;
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
    end else begin
      pclk_s1 <= pixel_output_clock;
      pclk_s2 <= pclk_s1;
      pclk_s3 <= pclk_s2;
      trig_s1 <= capture_request;
      trig_s2 <= trig_s1;
    end
  end

  // ==========================================================
  // Sequencer
  seq_state_t st_reg;
  logic [CNT_W-1:0] row_cnt_reg, col_cnt_reg;
  logic mirror_col_l, mirror_row_l;
  logic [CNT_W-1:0] flines_l, llen_l, rows_l, cols_l, integ_stage, integ_live;
  logic tick_pend_reg, adv, row_end, in_ready, in_valid;
  logic frame_end, blank_end, integ_end, restart_now, single_start, video_start;
  logic full_apply, sync_apply;
  logic [CNT_W-1:0] col_addr, row_addr;
  logic timing_write;

  // Consecutive high count only while the frame is inactive [R14]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_cnt_reg <= 2'h0;
    end else if (!trig_s2 || frame_active_flag) begin
      trig_cnt_reg <= 2'h0;
    end else if (trig_cnt_reg != TRIG_HIGH_CYCLES - 2'h1) begin
      trig_cnt_reg <= trig_cnt_reg + 2'h1;
    end
  end
  assign trig_ok = trig_s2 && !frame_active_flag && (trig_cnt_reg == TRIG_HIGH_CYCLES - 2'h1); // [R14]

  // A stall holds the tick; ticks seen while idle are dropped so start latency is fixed [R17]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_pend_reg <= 1'b0;
    end else if (pclk_s2 && !pclk_s3 && st_reg != ST_WAIT) begin
      tick_pend_reg <= 1'b1;
    end else if (adv || st_reg == ST_WAIT) begin
      tick_pend_reg <= 1'b0;
    end
  end

  assign adv = tick_pend_reg && in_ready && (st_reg != ST_WAIT);
  assign row_end = adv && (col_cnt_reg >= llen_l - 12'h001);
  assign frame_end = row_end && (st_reg == ST_ACTIVE) && (row_cnt_reg >= rows_l - 12'h001);
  assign blank_end = row_end && (st_reg == ST_BLANK) && (row_cnt_reg >= flines_l - rows_l - 12'h001);
  assign integ_end = row_end && (st_reg == ST_INTEG) && (row_cnt_reg >= integ_live - 12'h001);
  assign restart_now = restart_pend_reg && (row_end || st_reg == ST_WAIT); // [R11]
  assign video_start = (st_reg == ST_WAIT) && ctrl_reg[1] && ctrl_reg[0];
  // Fixed latency from request to integration keeps shared-request sensors aligned [R17]
  assign single_start = (st_reg == ST_WAIT) && ctrl_reg[1] && !ctrl_reg[0] && trig_ok;
  assign full_apply = restart_now || single_start || video_start; // [R08] [R10]
  assign sync_apply = frame_end && !restart_now; // [R07]
  assign timing_write = wr_fire && (aw_addr_reg == ADDR_READ_MODE || aw_addr_reg == ADDR_FRAME_LINES ||
                                    aw_addr_reg == ADDR_LINE_LEN || aw_addr_reg == ADDR_WINDOW);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restart_pend_reg <= 1'b0;
    end else if (wr_fire && aw_addr_reg == ADDR_CTRL && w_strb_reg[0] && w_data_reg[CTRL_RESTART_BIT]) begin
      restart_pend_reg <= 1'b1;
    end else if (restart_now) begin
      restart_pend_reg <= 1'b0;
    end
  end

  // Any timing write in video mode, even of an unchanged value, forces a bubble [R04]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bubble_pend_reg <= 1'b0;
    end else if (timing_write && ctrl_reg[0]) begin
      bubble_pend_reg <= 1'b1;
    end else if (full_apply || (blank_end && ctrl_reg[0])) begin
      bubble_pend_reg <= 1'b0;
    end
  end

  // Live copies of frame-synchronized fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mirror_col_l <= 1'b0;
      mirror_row_l <= 1'b0;
      flines_l <= FRAME_LINES_RST;
      llen_l <= LINE_LEN_RST;
      rows_l <= ROWS_RST;
      cols_l <= COLS_RST;
      integ_stage <= INTEG_RST;
      integ_live <= INTEG_RST;
    end else if (full_apply || sync_apply) begin
      mirror_col_l <= mirror_col_reg;
      mirror_row_l <= mirror_row_reg;
      flines_l <= frame_lines_reg;
      llen_l <= line_len_reg; // [R05]
      rows_l <= rows_reg;
      cols_l <= cols_reg;
      if (full_apply) begin
        integ_stage <= integ_reg;
        integ_live <= integ_reg; // [R10]
      end else begin
        integ_stage <= integ_reg;
        integ_live <= integ_stage; // [R06]
      end
    end
  end

  // Reset pass (integ) then sampling pass (active) [R12]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= ST_WAIT;
    end else if (restart_now && ctrl_reg[1]) begin
      st_reg <= ST_INTEG; // [R10]
    end else if (!ctrl_reg[1]) begin
      st_reg <= ST_WAIT;
    end else begin
      unique case (st_reg)
        ST_WAIT: if (video_start || single_start) st_reg <= ST_INTEG; // [R13]
        ST_INTEG: if (integ_end) st_reg <= ST_ACTIVE; // [R05]
        ST_ACTIVE: if (frame_end) st_reg <= ST_BLANK;
        ST_BLANK: begin
          if (blank_end) begin
            if (!ctrl_reg[0]) st_reg <= ST_WAIT; // [R13]
            else if (bubble_pend_reg) st_reg <= ST_INTEG; // [R04]
            else st_reg <= ST_ACTIVE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      row_cnt_reg <= '0;
      col_cnt_reg <= '0;
    end else if (restart_now || st_reg == ST_WAIT) begin
      row_cnt_reg <= '0;
      col_cnt_reg <= '0;
    end else if (row_end) begin
      col_cnt_reg <= '0;
      row_cnt_reg <= (frame_end || blank_end || integ_end) ? '0 : row_cnt_reg + 12'h001;
    end else if (adv) begin
      col_cnt_reg <= col_cnt_reg + 12'h001;
    end
  end

  assign frame_active_flag = (st_reg == ST_ACTIVE); // [R18]
  assign strobe_out = (st_reg == ST_INTEG) || (st_reg == ST_ACTIVE); // [R15]
  // Pair swap on the reversed order keeps the first color of each row
  assign col_addr = mirror_col_l ? ((cols_l - 12'h001 - col_cnt_reg) ^ 12'h001) : col_cnt_reg; // [R01]
  // Reversed rows shifted by one to keep the starting color
  assign row_addr = mirror_row_l ? (rows_l - row_cnt_reg) : row_cnt_reg; // [R03]
  assign in_valid = adv && frame_active_flag && (col_cnt_reg < cols_l);

  // ==========================================================
  // Two-entry output buffer
  logic [11:0] buf_mem [2];
  logic wr_ptr_reg, rd_ptr_reg;
  logic [1:0] buf_cnt_reg;
  logic push, pop;

  assign in_ready = (buf_cnt_reg != 2'h2);
  assign push = in_valid && in_ready;
  assign pop = pixel_valid && pixel_ready;
  assign pixel_valid = (buf_cnt_reg != 2'h0);
  assign pixel_data = buf_mem[rd_ptr_reg];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
      buf_mem[0] <= 12'h000;
      buf_mem[1] <= 12'h000;
    end else begin
      if (push) begin
        buf_mem[wr_ptr_reg] <= {row_addr[5:0], col_addr[5:0]};
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (pop) rd_ptr_reg <= !rd_ptr_reg;
      buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // ==========================================================
  // Register read
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL: rd_word = {29'h0, ctrl_reg[1], 1'b0, ctrl_reg[0]};
      ADDR_READ_MODE: rd_word = {16'h0, mirror_row_reg, mirror_col_reg, 14'h0};
      ADDR_FRAME_LINES: rd_word = {20'h0, frame_lines_reg};
      ADDR_LINE_LEN: rd_word = {20'h0, line_len_reg};
      ADDR_WINDOW: rd_word = {4'h0, cols_reg, 4'h0, rows_reg};
      ADDR_INTEG: rd_word = {20'h0, integ_reg};
      ADDR_STATUS: rd_word = {4'h0, row_cnt_reg, 10'h0, restart_pend_reg, bubble_pend_reg,
                              st_reg, strobe_out, frame_active_flag};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_trig_three_high: assert property (single_start |-> trig_s2 && $past(trig_s2, 1) && $past(trig_s2, 2)) // [R14]
    else $error("single frame started without three high request samples");
  a_fv_row_span: assert property ($fell(frame_active_flag) && !$past(restart_now) && $past(ctrl_reg[1]) |-> // [R18]
                                  $past(row_cnt_reg) == $past(rows_l) - 12'h001)
    else $error("frame flag fell before last row");
  a_strobe_integ: assert property (st_reg == ST_INTEG |-> strobe_out) // [R15]
    else $error("strobe low during integration");
  a_restart_row_end: assert property (restart_pend_reg && !row_end && st_reg != ST_WAIT |=> st_reg == $past(st_reg)) // [R11]
    else $error("restart did not wait for row end");
  a_restart_apply: assert property (restart_now && ctrl_reg[1] |=> st_reg == ST_INTEG && row_cnt_reg == 12'h000 &&
                                    integ_live == $past(integ_reg) && flines_l == $past(frame_lines_reg)) // [R10]
    else $error("restart did not apply pending writes");
  a_integ_two_frames: assert property (sync_apply && !full_apply |=> integ_live == $past(integ_stage)) // [R06]
    else $error("integration time not delayed by two frames");
  a_sync_next_frame: assert property (sync_apply |=> flines_l == $past(frame_lines_reg) && rows_l == $past(rows_reg)) // [R07]
    else $error("frame synchronized field not applied at frame end");
  a_bubble_restart: assert property (blank_end && ctrl_reg[0] && bubble_pend_reg && !restart_now |=> st_reg == ST_INTEG) // [R04]
    else $error("timing write did not cause a bubble");
  a_bubble_length: assert property (integ_end && !restart_now |=> st_reg == ST_ACTIVE) // [R05]
    else $error("integration pass length wrong");
  a_single_stops: assert property (blank_end && !ctrl_reg[0] && !restart_now && ctrl_reg[1] |=> st_reg == ST_WAIT) // [R13]
    else $error("single frame mode did not stop at frame end");
  a_col_mirror: assert property (push && mirror_col_l |-> col_addr == ((cols_l - 12'h001 - col_cnt_reg) ^ 12'h001)) // [R01]
    else $error("column mirror order wrong");
  a_row_mirror: assert property (push && mirror_row_l |=> // [R03]
                                 buf_mem[$past(wr_ptr_reg)][11:6] == 6'($past(rows_l) - $past(row_cnt_reg)))
    else $error("row mirror order wrong");
  a_ctrl_immediate: assert property (wr_fire && aw_addr_reg == ADDR_CTRL && w_strb_reg[0] |=>
                                     ctrl_reg[0] == $past(w_data_reg[CTRL_VIDEO_BIT])) // [R09]
    else $error("mode field not updated at write completion");

  c_single_frame: cover property (single_start ##[1:1000] frame_end);
  c_bubble: cover property (blank_end && bubble_pend_reg && ctrl_reg[0]);
  c_restart: cover property (restart_now && st_reg == ST_ACTIVE);
  c_buffer_full: cover property (buf_cnt_reg == 2'h2 && !pixel_ready);
endmodule

// ---- testbench/pixel_partner.sv ----
// Purpose: Far-side model with a free pixel clock and a stalling pixel receiver
// Assumes: One pixel word per accepted handshake
// Notes:   Counts words between rising edges of the frame-active flag
`timescale 1ns/1ps
module pixel_partner (
  // Clock
  input wire logic aclk,
  // Sensor side
  input wire logic frame_active_flag,
  input wire logic [11:0] pixel_data,
  input wire logic pixel_valid,
  output logic pixel_ready,
  output logic pixel_output_clock,
  // Bench side
  input wire logic stall,
  output logic [11:0] first_word,
  output int frame_words
);
  logic [1:0] phase_reg = 2'h0;
  logic flag_reg = 1'h0;
  logic got_reg = 1'h0;
  int cnt_reg = 0;
  // ==========================================================
  // Pixel clock
  // Runs free, phase unrelated to aclk
  initial begin
    pixel_output_clock = 1'h0;
    #37;
    forever #200 pixel_output_clock = ~pixel_output_clock;
  end
  // ==========================================================
  // Receiver
  // Stalls half the cycles on request; the source holds its tick while the buffer is full
  assign pixel_ready = !(stall && phase_reg[1]);
  always_ff @(posedge aclk) begin
    phase_reg <= phase_reg + 2'h1;
    flag_reg <= frame_active_flag;
    if (frame_active_flag && !flag_reg) begin
      frame_words <= cnt_reg;
      cnt_reg <= 0;
      got_reg <= 1'h0;
    end else if (pixel_valid && pixel_ready) begin
      cnt_reg <= cnt_reg + 1;
      got_reg <= 1'h1;
      if (!got_reg) first_word <= pixel_data;
    end
  end
endmodule

// ---- testbench/testbench.sv ----
// Purpose: Register and frame sequencing tests of the readout sequencer
// Assumes: 4x4 window, 8 frame lines, pixel tick every 8 aclk cycles
// Notes:   Durations allow about one and a half ticks of synchronizer slack
`timescale 1ns/1ps
module testbench import readout_pkg::*;;
  localparam int TICK = 8;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic capture_request = 1'h0, stall = 1'h0;
  logic pixel_output_clock, frame_active_flag, strobe_out, pixel_valid, pixel_ready;
  logic [11:0] pixel_data, first_word;
  int frame_words, c, fails = 0, samples_checked = 0;
  always #25 aclk = ~aclk;
  frame_readout_sequencer dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pixel_output_clock,
    .capture_request, .frame_active_flag, .strobe_out, .pixel_data, .pixel_valid, .pixel_ready);
  pixel_partner partner_u (.aclk, .frame_active_flag, .pixel_data, .pixel_valid, .pixel_ready,
    .pixel_output_clock, .stall, .first_word, .frame_words);
  // ==========================================================
  // Checks and bus tasks
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic hang();
    $display("[FAIL] %0t wait ran out, got %0h expected %0h", $time, 0, 1);
    fails++;
    give_verdict();
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cmp_near(input int got, input int exp, input int tol);
    samples_checked++;
    if (got < exp - tol || got > exp + tol) begin
      fails++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    if (n == 50) hang();
    s_axi_bready <= 1'h0;
    cmp_word({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    if (n == 50) hang();
    s_axi_rready <= 1'h0;
    cmp_word(s_axi_rdata, ed);
    cmp_word({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // A wait that is expected to run out passes must as 0
  task automatic wait_flag(input logic v, input int lim, input bit must, output int n);
    for (n = 0; n < lim; n++) begin
      @(posedge aclk);
      if (frame_active_flag === v) break;
    end
    if (must && n == lim) hang();
    // One more edge so the partner's frame counts have settled
    @(posedge aclk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ADDR_CTRL, {30'h0, CTRL_RST}, RESP_OKAY);
    rd(ADDR_FRAME_LINES, {20'h0, FRAME_LINES_RST}, RESP_OKAY);
    rd(ADDR_LINE_LEN, {20'h0, LINE_LEN_RST}, RESP_OKAY);
    rd(ADDR_WINDOW, {4'h0, COLS_RST, 4'h0, ROWS_RST}, RESP_OKAY);
    rd(ADDR_INTEG, {20'h0, INTEG_RST}, RESP_OKAY);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    wr(ADDR_STATUS, 32'hFFFFFFFF, RESP_SLVERR);
    wr(ADDR_WINDOW, 32'h00040004, RESP_OKAY);
    wr(ADDR_FRAME_LINES, 32'h8, RESP_OKAY);
    wr(ADDR_LINE_LEN, 32'h6, RESP_OKAY);
    wr(ADDR_INTEG, 32'h2, RESP_OKAY);
    wr(ADDR_CTRL, 32'h5, RESP_OKAY);
    repeat (TICK) @(posedge aclk);
    cmp_word({30'h0, strobe_out, frame_active_flag}, 32'h2);
    wait_flag(1'h1, 1000, 1'b1, c);
    wait_flag(1'h0, 1000, 1'b1, c);
    cmp_near(c, 4 * 6 * TICK, 12);
    wait_flag(1'h1, 1000, 1'b1, c);
    cmp_near(c, 4 * 6 * TICK, 12);
    cmp_word(frame_words, 32'h10);
    cmp_word({20'h0, first_word}, 32'h0);
    // Mirror and line length land mid-frame, so this frame is unchanged
    wr(ADDR_READ_MODE, 32'hC000, RESP_OKAY);
    wr(ADDR_LINE_LEN, 32'hA, RESP_OKAY);
    wait_flag(1'h0, 1000, 1'b1, c);
    wait_flag(1'h1, 1000, 1'b1, c);
    cmp_near(c, (4 + 2) * 10 * TICK, 12);
    cmp_word({20'h0, first_word}, 32'h0);
    wait_flag(1'h0, 1000, 1'b1, c);
    cmp_near(c, 4 * 10 * TICK, 12);
    wait_flag(1'h1, 1000, 1'b1, c);
    cmp_near(c, 4 * 10 * TICK, 12);
    cmp_word({20'h0, first_word}, 32'h102);
    cmp_word(frame_words, 32'h10);
    wr(ADDR_INTEG, 32'h3, RESP_OKAY);
    wr(ADDR_CTRL, 32'h7, RESP_OKAY);
    wait_flag(1'h0, 10 * TICK + 20, 1'b1, c);
    cmp_word({31'h0, strobe_out}, 32'h1);
    wait_flag(1'h1, 1000, 1'b1, c);
    cmp_near(c, 3 * 10 * TICK, 12);
    rd(ADDR_CTRL, 32'h5, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    @(posedge aclk);
    cmp_word({31'h0, frame_active_flag}, 32'h0);
    wr(ADDR_READ_MODE, 32'h0, RESP_OKAY);
    wr(ADDR_CTRL, 32'h4, RESP_OKAY);
    wait_flag(1'h1, 400, 1'b0, c);
    cmp_near(c, 400, 0);
    capture_request <= 1'h1;
    repeat (2) @(posedge aclk);
    capture_request <= 1'h0;
    wait_flag(1'h1, 400, 1'b0, c);
    cmp_near(c, 400, 0);
    capture_request <= 1'h1;
    stall <= 1'h1;
    wait_flag(1'h1, 400, 1'b1, c);
    cmp_near(c, 3 * 10 * TICK + 5, 12);
    wait_flag(1'h0, 1000, 1'b1, c);
    wait_flag(1'h1, 1000, 1'b1, c);
    cmp_word({20'h0, first_word}, 32'h0);
    cmp_word(frame_words, 32'h10);
    capture_request <= 1'h0;
    wait_flag(1'h0, 1000, 1'b1, c);
    wait_flag(1'h1, 1500, 1'b0, c);
    cmp_near(c, 1500, 0);
    give_verdict();
  end
endmodule
